// ---- hdl/tkirq_pkg.sv ----
// Constants, register map and state type of the touch interrupt aggregator.
// Assumes byte-wide register access from the serial port logic outside.
package tkirq_pkg;

    // ==========================================================
    // Sizes
    localparam int TKIRQ_NGPIO = 16;
    localparam int TKIRQ_NPWM  = 8;

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] TKIRQ_ADDR_CTRL    = 8'h06;
    localparam logic [7:0] TKIRQ_ADDR_SUM_STA = 8'h08;
    localparam logic [7:0] TKIRQ_ADDR_SUM_EN  = 8'h09;
    localparam logic [7:0] TKIRQ_ADDR_PC_STA  = 8'h0a;
    localparam logic [7:0] TKIRQ_ADDR_PC_STAH = 8'h0b;
    localparam logic [7:0] TKIRQ_ADDR_PC_EN   = 8'h0c;
    localparam logic [7:0] TKIRQ_ADDR_PC_ENH  = 8'h0d;
    localparam logic [7:0] TKIRQ_ADDR_PWM_STA = 8'h0e;
    localparam logic [7:0] TKIRQ_ADDR_PWM_EN  = 8'h0f;

    // ==========================================================
    // Field positions
    localparam int TKIRQ_CTRL_EN   = 0;
    localparam int TKIRQ_CTRL_TYPE = 1;
    localparam int TKIRQ_CTRL_POL  = 2;
    localparam int TKIRQ_SUM_GPIO  = 7;
    localparam int TKIRQ_SUM_PWM   = 6;
    localparam int TKIRQ_SUM_WAKE  = 5;
    localparam int TKIRQ_SUM_ENV   = 4;
    localparam int TKIRQ_SUM_EOC   = 3;
    localparam int TKIRQ_SUM_TOUCH = 2;
    localparam int TKIRQ_SUM_RU2   = 1;
    localparam int TKIRQ_SUM_RU1   = 0;

    // ==========================================================
    // Reset values
    localparam logic [2:0]  TKIRQ_CTRL_RST = 3'h0;
    localparam logic [7:0]  TKIRQ_BYTE_RST = 8'h00;
    localparam logic [15:0] TKIRQ_WORD_RST = 16'h0000;
    localparam logic        TKIRQ_PIN_RST  = 1'b1;

    typedef struct packed {
        logic [2:0]              ctrl;
        logic [7:0]              sum_sta;
        logic [7:0]              sum_en;
        logic [TKIRQ_NGPIO-1:0]  pc_en;
        logic [TKIRQ_NPWM-1:0]   pwm_en;
        logic [TKIRQ_NGPIO-1:0]  pin_prev;
        logic                    prev_valid;
        logic                    req_prev;
        logic                    irq_pin;
        logic [7:0]              rdata;
    } tkirq_state_t;

endpackage : tkirq_pkg

// ---- hdl/tkirq_bank_if.sv ----
// Carrier between the aggregator and one per-channel flag bank.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface tkirq_bank_if #(parameter int W = 8);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] en;
    logic [W-1:0] flags;
    logic         hit;

    modport owner (input set, input clr, input en, output flags, output hit);
    modport user  (output set, output clr, output en, input flags, input hit);
endinterface : tkirq_bank_if

// ---- hdl/tkirq_flag_bank.sv ----
// Sticky per-channel flags, hardware set, write-one-to-clear.
// Assumes set and clear arrive as one-cycle vectors from the aggregator.
`timescale 1ns/10ps
module tkirq_flag_bank #(
    parameter int W = 8
) (
    input wire logic        sys_clk, // System clock
    input wire logic        rstn,    // Synchronous reset, active low
    input wire logic        ce,      // Clock enable
    tkirq_bank_if.owner     bank     // Flag bank carrier
);

    typedef struct packed {
        logic [W-1:0] flags;
    } tkirq_bank_st_t;

    tkirq_bank_st_t st_q;
    tkirq_bank_st_t st_d;
    logic [W-1:0]   nxt;

    // ==========================================================
    // Per-bit next value, set wins over clear
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign nxt[i] = bank.set[i] | (st_q.flags[i] & ~bank.clr[i]);
    end

    assign bank.flags = st_q.flags;
    assign bank.hit   = |(bank.set & bank.en);

    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.flags = nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Checks
    a_bank_set_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce |=> ((bank.flags & $past(bank.set)) == $past(bank.set)))
        else $error("flag set lost");
    a_bank_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce |=> ((bank.flags & $past(bank.clr) & ~$past(bank.set)) == '0))
        else $error("flag not cleared by write one");

endmodule : tkirq_flag_bank

// ---- hdl/tkirq_aggregator.sv ----
// Interrupt aggregator of a capacitive touch controller: summary and
// per-channel flags, enables and the configurable host interrupt line.
// Assumes byte register accesses from the serial port logic, event inputs
// as one-cycle pulses and GPIO inputs synchronous to sys_clk.
//
// What this block does
// - Interrupt pin is active low when polarity bit is 0, high when 1.
// - Trigger-kind bit 0 gives a level interrupt, 1 gives an edge.
// - Output asserts only while master enable bit 0 is set.
// - Summary bits 7..0: GPIO, PWM, wake, env, cal done, touch, RE2, RE1.
// - Writing one clears a summary flag; zero leaves it.
// - Summary bit 7 sets on a pin-change event of a GPIO channel whose pin-change enable bit is set.
// - Summary bit 6 sets when a PWM channel whose PWM-done enable bit is set finishes its sequence.
// - Summary bit 5 sets on leaving sleep or hibernate.
// - Summary bit 4 sets on stuck calibration or tuning out of range.
// - Summary bit 3 sets when a host calibration completes.
// - Summary bit 2 sets when a touch key touch is detected.
// - Summary bits 1 and 0 set on ratio engine 2 and 1 events.
// - Summary enable mirrors status layout; one lets a source interrupt.
// - Touch key filter data is active only while touch enable is set.
// - Pin-change bit sets when an input GPIO changes state.
// - Writing one clears a pin-change bit; zero leaves it.
// - Pin-change enable bits let matching GPIO events interrupt.
// - PWM-done bit sets on sequence end; write one clears it.
// - PWM-done enable bits let matching channels interrupt.
`timescale 1ns/10ps
module tkirq_aggregator
    import tkirq_pkg::*;
(
    input  wire logic                   sys_clk,        // 100 MHz clock
    input  wire logic                   rstn,           // Sync reset
    input  wire logic                   ce,             // Clock enable
    input  wire logic [7:0]             reg_addr,       // Register address
    input  wire logic                   reg_wr,         // Write strobe
    input  wire logic [7:0]             reg_wdata,      // Write data
    input  wire logic                   reg_rd,         // Read strobe
    output wire logic [7:0]             reg_rdata,      // Read data
    input  wire logic [TKIRQ_NGPIO-1:0] gpio_pin_in,    // GPIO pin levels
    input  wire logic [TKIRQ_NGPIO-1:0] gpio_dir_out,   // 1: pin is output
    input  wire logic [TKIRQ_NPWM-1:0]  pwm_seq_done,   // Sequence end
    input  wire logic                   wake_evt,       // Left sleep
    input  wire logic                   cal_stuck_evt,  // Calib stuck
    input  wire logic                   tune_range_evt, // Tuning range
    input  wire logic                   cal_done_evt,   // Calib complete
    input  wire logic                   touch_evt,      // Key touched
    input  wire logic                   ratio_unit2_event, // Engine 2
    input  wire logic                   ratio_unit1_event, // Engine 1
    output wire logic                   irq_out,        // Host interrupt
    output wire logic                   touch_filter_en // Key filter on
);

    tkirq_state_t st_q;
    tkirq_state_t st_d;

    tkirq_bank_if #(.W(TKIRQ_NGPIO)) pc_bank ();
    tkirq_bank_if #(.W(TKIRQ_NPWM))  pwm_bank ();

    logic       wr_ctrl;
    logic       wr_sum_sta;
    logic       wr_sum_en;
    logic       wr_pc_lo;
    logic       wr_pc_hi;
    logic       wr_pce_lo;
    logic       wr_pce_hi;
    logic       wr_pwm_sta;
    logic       wr_pwm_en;
    logic [7:0] sum_set;
    logic [7:0] sum_clr;
    logic       req;
    logic       irq_act;
    logic       irq_pol;
    logic       edge_mode;
    logic [7:0] rd_mux;

    // ==========================================================
    // Register write decode
    always_comb begin
        wr_ctrl    = reg_wr && (reg_addr == TKIRQ_ADDR_CTRL);
        wr_sum_sta = reg_wr && (reg_addr == TKIRQ_ADDR_SUM_STA);
        wr_sum_en  = reg_wr && (reg_addr == TKIRQ_ADDR_SUM_EN);
        wr_pc_lo   = reg_wr && (reg_addr == TKIRQ_ADDR_PC_STA);
        wr_pc_hi   = reg_wr && (reg_addr == TKIRQ_ADDR_PC_STAH);
        wr_pce_lo  = reg_wr && (reg_addr == TKIRQ_ADDR_PC_EN);
        wr_pce_hi  = reg_wr && (reg_addr == TKIRQ_ADDR_PC_ENH);
        wr_pwm_sta = reg_wr && (reg_addr == TKIRQ_ADDR_PWM_STA);
        wr_pwm_en  = reg_wr && (reg_addr == TKIRQ_ADDR_PWM_EN);
    end

    // ==========================================================
    // Per-channel banks
    assign pc_bank.set = st_q.prev_valid
                       ? ((gpio_pin_in ^ st_q.pin_prev) & ~gpio_dir_out)
                       : TKIRQ_WORD_RST;
    assign pc_bank.clr = {wr_pc_hi ? reg_wdata : TKIRQ_BYTE_RST,
                          wr_pc_lo ? reg_wdata : TKIRQ_BYTE_RST};
    assign pc_bank.en  = st_q.pc_en;

    assign pwm_bank.set = pwm_seq_done;
    assign pwm_bank.clr = wr_pwm_sta ? reg_wdata : TKIRQ_BYTE_RST;
    assign pwm_bank.en  = st_q.pwm_en;

    tkirq_flag_bank #(.W(TKIRQ_NGPIO)) u_pc_bank (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .ce      (ce),
        .bank    (pc_bank)
    );

    tkirq_flag_bank #(.W(TKIRQ_NPWM)) u_pwm_bank (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .ce      (ce),
        .bank    (pwm_bank)
    );

    // ==========================================================
    // Summary sources
    always_comb begin
        sum_set                  = TKIRQ_BYTE_RST;
        sum_set[TKIRQ_SUM_GPIO]  = pc_bank.hit;
        sum_set[TKIRQ_SUM_PWM]   = pwm_bank.hit;
        sum_set[TKIRQ_SUM_WAKE]  = wake_evt;
        sum_set[TKIRQ_SUM_ENV]   = cal_stuck_evt | tune_range_evt;
        sum_set[TKIRQ_SUM_EOC]   = cal_done_evt;
        sum_set[TKIRQ_SUM_TOUCH] = touch_evt;
        sum_set[TKIRQ_SUM_RU2]   = ratio_unit2_event;
        sum_set[TKIRQ_SUM_RU1]   = ratio_unit1_event;
        sum_clr = wr_sum_sta ? reg_wdata : TKIRQ_BYTE_RST;
    end

    // ==========================================================
    // Interrupt request and pin
    assign irq_pol   = st_q.ctrl[TKIRQ_CTRL_POL];
    assign edge_mode = st_q.ctrl[TKIRQ_CTRL_TYPE];
    assign req       = st_q.ctrl[TKIRQ_CTRL_EN]
                     && |(st_q.sum_sta & st_q.sum_en);
    assign irq_act   = edge_mode ? (req && !st_q.req_prev) : req;

    // ==========================================================
    // Read data mux
    always_comb begin
        case (reg_addr)
            TKIRQ_ADDR_CTRL:    rd_mux = {5'h00, st_q.ctrl};
            TKIRQ_ADDR_SUM_STA: rd_mux = st_q.sum_sta;
            TKIRQ_ADDR_SUM_EN:  rd_mux = st_q.sum_en;
            TKIRQ_ADDR_PC_STA:  rd_mux = pc_bank.flags[7:0];
            TKIRQ_ADDR_PC_STAH: rd_mux = pc_bank.flags[15:8];
            TKIRQ_ADDR_PC_EN:   rd_mux = st_q.pc_en[7:0];
            TKIRQ_ADDR_PC_ENH:  rd_mux = st_q.pc_en[15:8];
            TKIRQ_ADDR_PWM_STA: rd_mux = pwm_bank.flags;
            TKIRQ_ADDR_PWM_EN:  rd_mux = st_q.pwm_en;
            default:            rd_mux = TKIRQ_BYTE_RST;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        if (ce) begin
            if (wr_ctrl) begin
                st_d.ctrl = reg_wdata[2:0];
            end
            if (wr_sum_en) begin
                st_d.sum_en = reg_wdata;
            end
            if (wr_pce_lo) begin
                st_d.pc_en[7:0] = reg_wdata;
            end
            if (wr_pce_hi) begin
                st_d.pc_en[15:8] = reg_wdata;
            end
            if (wr_pwm_en) begin
                st_d.pwm_en = reg_wdata;
            end
            if (reg_rd) begin
                st_d.rdata = rd_mux;
            end
            st_d.sum_sta    = sum_set | (st_q.sum_sta & ~sum_clr);
            st_d.pin_prev   = gpio_pin_in;
            st_d.prev_valid = 1'b1;
            st_d.req_prev   = req;
            st_d.irq_pin    = irq_pol ? irq_act : !irq_act;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_q.ctrl       <= TKIRQ_CTRL_RST;
            st_q.sum_sta    <= TKIRQ_BYTE_RST;
            st_q.sum_en     <= TKIRQ_BYTE_RST;
            st_q.pc_en      <= TKIRQ_WORD_RST;
            st_q.pwm_en     <= TKIRQ_BYTE_RST;
            st_q.pin_prev   <= TKIRQ_WORD_RST;
            st_q.prev_valid <= 1'b0;
            st_q.req_prev   <= 1'b0;
            st_q.irq_pin    <= TKIRQ_PIN_RST;
            st_q.rdata      <= TKIRQ_BYTE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign irq_out         = st_q.irq_pin;
    assign reg_rdata       = st_q.rdata;
    assign touch_filter_en = st_q.sum_en[TKIRQ_SUM_TOUCH];

    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // ==========================================================
    // Interrupt pin
    a_pol_low_level: assert property (
        ce && req && !edge_mode && !irq_pol |=> !irq_out)
        else $error("active low level not driven low");

    a_pol_high_level: assert property (
        ce && req && !edge_mode && irq_pol |=> irq_out)
        else $error("active high level not driven high");

    // Polarity held in both cycles; a swap moves the pin legally
    a_level_holds: assert property (
        ce && req && !edge_mode && irq_pol
        ##1 ce && req && !edge_mode && irq_pol
        |=> irq_out [*1])
        else $error("level interrupt not held");

    a_master_off: assert property (
        ce && !st_q.ctrl[TKIRQ_CTRL_EN] |=> (irq_out == !$past(irq_pol)))
        else $error("interrupt asserted while disabled");

    a_gate_req: assert property (
        ce && !edge_mode && st_q.ctrl[TKIRQ_CTRL_EN]
        && ((st_q.sum_sta & st_q.sum_en) == 8'h00)
        |=> (irq_out == !$past(irq_pol)))
        else $error("masked source raised interrupt");

    // Edge mode: active on the rise only, inactive after it
    a_edge_rise: assert property (
        ce && edge_mode && req && !st_q.req_prev
        |=> (irq_out == $past(irq_pol)))
        else $error("edge pulse missing");

    a_edge_pulse: assert property (
        ce && edge_mode && st_q.req_prev |=> (irq_out == !$past(irq_pol)))
        else $error("edge pulse longer than one cycle");

    // ==========================================================
    // Summary flags
    a_sum_w1c: assert property (
        ce && wr_sum_sta
        |=> ((st_q.sum_sta & $past(reg_wdata) & ~$past(sum_set)) == 8'h00))
        else $error("summary flag not cleared");

    // Flags move only on a source event or a write of one
    a_sum_keep: assert property (
        ce && !wr_sum_sta && (sum_set == 8'h00)
        |=> (st_q.sum_sta == $past(st_q.sum_sta)))
        else $error("summary flag changed without cause");

    a_sum_gpio: assert property (
        ce && |(pc_bank.set & st_q.pc_en) |=> st_q.sum_sta[TKIRQ_SUM_GPIO])
        else $error("gpio summary not set");

    // Events of masked channels stay out of the summary
    a_gpio_masked: assert property (
        ce && !st_q.sum_sta[TKIRQ_SUM_GPIO]
        && ((pc_bank.set & st_q.pc_en) == 16'h0000)
        |=> !st_q.sum_sta[TKIRQ_SUM_GPIO])
        else $error("masked pin change reached summary");

    a_sum_pwm: assert property (
        ce && |(pwm_seq_done & st_q.pwm_en) |=> st_q.sum_sta[TKIRQ_SUM_PWM])
        else $error("pwm summary not set");

    // Same for the sequence-done channels
    a_pwm_masked: assert property (
        ce && !st_q.sum_sta[TKIRQ_SUM_PWM]
        && ((pwm_seq_done & st_q.pwm_en) == 8'h00)
        |=> !st_q.sum_sta[TKIRQ_SUM_PWM])
        else $error("masked pwm done reached summary");

    a_sum_wake: assert property (
        ce && wake_evt |=> st_q.sum_sta[TKIRQ_SUM_WAKE])
        else $error("wake summary not set");

    a_sum_env: assert property (
        ce && (cal_stuck_evt || tune_range_evt) |=> st_q.sum_sta[TKIRQ_SUM_ENV])
        else $error("environment summary not set");

    a_sum_eoc: assert property (
        ce && cal_done_evt |=> st_q.sum_sta[TKIRQ_SUM_EOC])
        else $error("calibration summary not set");

    a_sum_touch: assert property (
        ce && touch_evt |=> st_q.sum_sta[TKIRQ_SUM_TOUCH])
        else $error("touch summary not set");

    // One check per ratio engine
    a_sum_ratio: assert property (
        ce && ratio_unit2_event |=> st_q.sum_sta[TKIRQ_SUM_RU2])
        else $error("ratio engine 2 summary not set");

    a_sum_ratio_one: assert property (
        ce && ratio_unit1_event |=> st_q.sum_sta[TKIRQ_SUM_RU1])
        else $error("ratio engine 1 summary not set");

    // ==========================================================
    // Per-channel flags and touch filter
    a_pin_change: assert property (
        ce && st_q.prev_valid && (gpio_pin_in[0] != st_q.pin_prev[0])
        && !gpio_dir_out[0] |=> pc_bank.flags[0])
        else $error("pin change not flagged");

    // Output pins never report a change
    a_pin_output: assert property (
        ce && st_q.prev_valid && gpio_dir_out[2] && !pc_bank.flags[2]
        |=> !pc_bank.flags[2])
        else $error("output pin flagged a change");

    a_pwm_flag: assert property (
        ce && pwm_seq_done[3] |=> pwm_bank.flags[3])
        else $error("pwm done flag not set");

    a_filter_en: assert property (
        ce && wr_sum_en |=> (touch_filter_en == $past(reg_wdata[2])))
        else $error("touch filter enable wrong");

    // ==========================================================
    // Main scenarios
    c_level_irq: cover property (ce && req && !edge_mode ##1 irq_out == irq_pol);
    c_edge_irq: cover property (ce && edge_mode && req && !st_q.req_prev);
    c_gpio_path: cover property (pc_bank.hit ##[1:20] wr_pc_lo);
    c_sum_clear: cover property (wr_sum_sta && |(st_q.sum_sta & reg_wdata));
    c_pwm_path: cover property (pwm_bank.hit ##[1:20] wr_pwm_sta);

endmodule : tkirq_aggregator

// ---- dv/tkirq_host_model.sv ----
// Host processor model: byte register master and interrupt service routine.
// Assumes the aggregator samples strobes at the sys_clk rising edge.
`timescale 1ns/10ps
module tkirq_host_model
    import tkirq_pkg::*;
(
    input  wire logic       sys_clk,   // System clock
    output logic [7:0]      reg_addr,  // Register address
    output logic            reg_wr,    // Write strobe
    output logic [7:0]      reg_wdata, // Write data
    output logic            reg_rd,    // Read strobe
    input  wire logic [7:0] reg_rdata  // Read data
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
        reg_rd    = 1'b0;
    end

    // ==========================================================
    // Bus cycles; released lines show inverted garbage
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : rd

    // ==========================================================
    // Service: summary, then per-channel clear, then summary clear
    task automatic service(output logic [7:0] sum);
        logic [7:0] v;
        rd(TKIRQ_ADDR_SUM_STA, sum);
        if (sum[TKIRQ_SUM_GPIO]) begin
            rd(TKIRQ_ADDR_PC_STA, v);
            wr(TKIRQ_ADDR_PC_STA, v);
            rd(TKIRQ_ADDR_PC_STAH, v);
            wr(TKIRQ_ADDR_PC_STAH, v);
        end
        if (sum[TKIRQ_SUM_PWM]) begin
            rd(TKIRQ_ADDR_PWM_STA, v);
            wr(TKIRQ_ADDR_PWM_STA, v);
        end
        wr(TKIRQ_ADDR_SUM_STA, sum);
    endtask : service
endmodule : tkirq_host_model

// ---- dv/tkirq_aggregator_tb.sv ----
// Self-checking bench of the touch interrupt aggregator.
// Assumes the host model drives the register port.
`timescale 1ns/10ps
module tkirq_aggregator_tb
    import tkirq_pkg::*;
;
    typedef struct packed {
        logic [6:0] evt;
        logic [7:0] sum;
    } tkirq_row_t;

    logic        sys_clk, rstn, ce, reg_wr, reg_rd, irq_out, touch_filter_en;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, pwm_seq_done, v;
    logic [15:0] gpio_pin_in, gpio_dir_out;
    logic [6:0]  evt;
    int          fail_count   = 0;
    int          total_checks = 0;
    // Environment alarm rows come before the calibration done row
    tkirq_row_t  rows [7] = '{'{7'h40, 8'h20}, '{7'h20, 8'h10},
        '{7'h10, 8'h10}, '{7'h08, 8'h08}, '{7'h04, 8'h04},
        '{7'h02, 8'h02}, '{7'h01, 8'h01}};

    tkirq_aggregator dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .gpio_pin_in(gpio_pin_in),
        .gpio_dir_out(gpio_dir_out), .pwm_seq_done(pwm_seq_done),
        .wake_evt(evt[6]), .cal_stuck_evt(evt[5]), .tune_range_evt(evt[4]),
        .cal_done_evt(evt[3]), .touch_evt(evt[2]),
        .ratio_unit2_event(evt[1]), .ratio_unit1_event(evt[0]),
        .irq_out(irq_out), .touch_filter_en(touch_filter_en));

    tkirq_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));

    // ==========================================================
    // Helpers
    task automatic chk(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : cyc

    task automatic pulse(input logic [6:0] e, input logic [7:0] p);
        @(posedge sys_clk);
        evt          <= e;
        pwm_seq_done <= p;
        @(posedge sys_clk);
        evt          <= 7'h00;
        pwm_seq_done <= 8'h00;
    endtask : pulse

    task automatic final_report;
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        #200us;
        fail_count++;
        final_report();
    end

    // ==========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        gpio_pin_in = 16'h0000;
        gpio_dir_out = 16'h0004;
        pwm_seq_done = 8'h00;
        evt = 7'h00;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        cyc(0);
        chk("irq_out reset", 8'(irq_out), 8'h01);
        for (int a = 6; a <= 16; a++) begin
            host.rd(8'(a), v);
            chk("reset value", v, 8'h00);
        end
        host.wr(TKIRQ_ADDR_CTRL, 8'hff);
        host.rd(TKIRQ_ADDR_CTRL, v);
        chk("ctrl reserved", v, 8'h07);
        // Summary sources one by one, level mode, active low
        foreach (rows[i]) begin
            host.wr(TKIRQ_ADDR_SUM_EN, rows[i].sum);
            host.wr(TKIRQ_ADDR_CTRL, 8'h01);
            cyc(0);
            chk("filter_en", 8'(touch_filter_en), 8'(rows[i].sum[2]));
            pulse(rows[i].evt, 8'h00);
            cyc(1);
            chk("irq active", 8'(irq_out), 8'h00);
            host.rd(TKIRQ_ADDR_SUM_STA, v);
            chk("sum flag", v, rows[i].sum);
            host.wr(TKIRQ_ADDR_SUM_STA, ~rows[i].sum);
            host.rd(TKIRQ_ADDR_SUM_STA, v);
            chk("sum zero write", v, rows[i].sum);
            host.wr(TKIRQ_ADDR_SUM_STA, rows[i].sum);
            cyc(1);
            chk("irq cleared", 8'(irq_out), 8'h01);
            host.rd(TKIRQ_ADDR_SUM_STA, v);
            chk("sum clear", v, 8'h00);
        end
        // GPIO: disabled channel, output pin, both bytes, active high
        host.wr(TKIRQ_ADDR_PC_EN, 8'h01);
        host.wr(TKIRQ_ADDR_PC_ENH, 8'h80);
        host.wr(TKIRQ_ADDR_SUM_EN, 8'h80);
        host.wr(TKIRQ_ADDR_CTRL, 8'h05);
        @(posedge sys_clk);
        gpio_pin_in <= 16'h0002;
        cyc(2);
        chk("irq gpio off", 8'(irq_out), 8'h00);
        host.rd(TKIRQ_ADDR_SUM_STA, v);
        chk("sum gpio off", v, 8'h00);
        @(posedge sys_clk);
        gpio_pin_in <= 16'h8007;
        cyc(2);
        chk("irq gpio", 8'(irq_out), 8'h01);
        host.wr(TKIRQ_ADDR_PC_STA, 8'h00);
        host.rd(TKIRQ_ADDR_PC_STA, v);
        chk("pc low", v, 8'h03);
        host.rd(TKIRQ_ADDR_PC_STAH, v);
        chk("pc high", v, 8'h80);
        host.service(v);
        chk("sum gpio", v, 8'h80);
        cyc(1);
        chk("irq gpio done", 8'(irq_out), 8'h00);
        host.rd(TKIRQ_ADDR_PC_STA, v);
        chk("pc cleared", v, 8'h00);
        // PWM: enabled and disabled channel together
        host.wr(TKIRQ_ADDR_PWM_EN, 8'h08);
        host.wr(TKIRQ_ADDR_SUM_EN, 8'h40);
        pulse(7'h00, 8'h28);
        cyc(1);
        chk("irq pwm", 8'(irq_out), 8'h01);
        host.rd(TKIRQ_ADDR_PWM_STA, v);
        chk("pwm status", v, 8'h28);
        host.service(v);
        cyc(1);
        host.rd(TKIRQ_ADDR_PWM_STA, v);
        chk("pwm cleared", v, 8'h00);
        // Master enable off, then polarity swap with a flag pending
        host.wr(TKIRQ_ADDR_CTRL, 8'h04);
        pulse(7'h00, 8'h08);
        cyc(1);
        chk("irq masked", 8'(irq_out), 8'h00);
        host.wr(TKIRQ_ADDR_CTRL, 8'h05);
        cyc(1);
        chk("irq unmasked", 8'(irq_out), 8'h01);
        host.wr(TKIRQ_ADDR_CTRL, 8'h01);
        cyc(1);
        chk("irq low pol", 8'(irq_out), 8'h00);
        host.service(v);
        // Edge mode: one cycle pulse only
        host.wr(TKIRQ_ADDR_SUM_EN, 8'h01);
        host.wr(TKIRQ_ADDR_CTRL, 8'h03);
        pulse(7'h01, 8'h00);
        cyc(1);
        chk("edge pulse", 8'(irq_out), 8'h00);
        cyc(1);
        chk("edge end", 8'(irq_out), 8'h01);
        cyc(3);
        chk("edge held", 8'(irq_out), 8'h01);
        // Clock enable low drops the write
        @(posedge sys_clk);
        ce <= 1'b0;
        host.wr(TKIRQ_ADDR_SUM_EN, 8'hff);
        ce <= 1'b1;
        host.rd(TKIRQ_ADDR_SUM_EN, v);
        chk("ce low write", v, 8'h01);
        // Reset in mid-run
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        host.rd(TKIRQ_ADDR_CTRL, v);
        chk("ctrl rereset", v, 8'h00);
        chk("irq rereset", 8'(irq_out), 8'h01);
        final_report();
    end
endmodule : tkirq_aggregator_tb
